/* rtl/cwt_pkg.sv */
package cwt_pkg;

    localparam int NUM_TIMERS = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Byte offsets of the register map; timer n sits at n * TIMER_STRIDE.
    localparam logic [7:0] TIMER_STRIDE = 8'h10;
    localparam logic [7:0] OFS_ON = 8'h00;
    localparam logic [7:0] OFS_OFF = 8'h04;
    localparam logic [7:0] OFS_MODE = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_CTRL = 8'h40;
    localparam logic [7:0] MAP_TIMER_END = 8'h40;

    // Field positions of the time-of-day registers.
    localparam int SEC_LSB = 0;
    localparam int MIN_LSB = 8;
    localparam int HOUR_LSB = 16;

    // Field positions of the status and control registers.
    localparam int STAT_OUT_BIT = 0;
    localparam int STAT_INUSE_BIT = 1;
    localparam int CTRL_RESTORED_BIT = 0;
    localparam int CTRL_PFAIL_BIT = 1;

    // Mode selector codes.
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_DAILY = 4'h1;
    localparam logic [3:0] MODE_MON = 4'h2;
    localparam logic [3:0] MODE_SUN = 4'h8;
    localparam logic [3:0] MODE_WEEKDAYS = 4'h9;
    localparam logic [3:0] MODE_MON_SAT = 4'ha;
    localparam logic [3:0] MODE_WEEKEND = 4'hb;

    // Day-of-week codes, Monday first.
    localparam logic [2:0] DOW_MON = 3'h0;
    localparam logic [2:0] DOW_FRI = 3'h4;
    localparam logic [2:0] DOW_SAT = 3'h5;
    localparam logic [2:0] DOW_SUN = 3'h6;

    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } cwt_tod_t;

    typedef struct packed {
        cwt_tod_t tod;
        logic [2:0] dow;
    } cwt_cal_t;

    localparam cwt_tod_t TOD_RST = 17'h00000;

    typedef enum logic {CWT_RESTORE, CWT_RUN} cwt_phase_t;

    typedef struct packed {
        cwt_phase_t phase;
        cwt_tod_t [NUM_TIMERS-1:0] on_tod;
        cwt_tod_t [NUM_TIMERS-1:0] off_tod;
        logic [NUM_TIMERS-1:0][3:0] mode;
        logic [NUM_TIMERS-1:0] state;
        logic [NUM_TIMERS-1:0] tout;
        logic [5:0] prev_sec;
        logic [1:0] pf_sync;
        logic pf_seen;
        logic save_stb;
        logic [NUM_TIMERS-1:0] save_data;
        logic waitreq;
        logic [DATA_W-1:0] rdata;
    } cwt_state_t;

    localparam cwt_state_t STATE_RST = '{
        CWT_RESTORE, {NUM_TIMERS{TOD_RST}}, {NUM_TIMERS{TOD_RST}},
        {NUM_TIMERS{MODE_OFF}}, 4'h0, 4'h0, 6'h00, 2'h0, 1'b0, 1'b0,
        4'h0, 1'b1, 32'h00000000
    };

endpackage

/* rtl/cwt_timers.sv */
`timescale 1ns/1ps
`default_nettype none

module cwt_timers (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [cwt_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [cwt_pkg::DATA_W-1:0] AVS_WRITEDATA,
    output logic [cwt_pkg::DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire cwt_pkg::cwt_cal_t CAL_TIME,
    input wire logic AUX_POWER_FAIL,
    input wire logic NV_LOAD_VALID,
    input wire logic [cwt_pkg::NUM_TIMERS-1:0] NV_LOAD_DATA,
    output logic NV_SAVE_STB,
    output logic [cwt_pkg::NUM_TIMERS-1:0] NV_SAVE_DATA,
    output logic [cwt_pkg::NUM_TIMERS-1:0] TIMER_OUT
);

    cwt_pkg::cwt_state_t q_r;
    cwt_pkg::cwt_state_t q_nxt;

    logic [cwt_pkg::NUM_TIMERS-1:0] day_on_ok;
    logic [cwt_pkg::NUM_TIMERS-1:0] day_off_ok;
    logic [cwt_pkg::NUM_TIMERS-1:0] in_use;
    logic [2:0] dow_prev;
    logic sec_tick;

    // Whether a mode selects a given day of the week.
    function automatic logic day_selected(
        input logic [3:0] mode,
        input logic [2:0] dow
    );
        logic sel;
        sel = 1'b0;
        case (mode)
            cwt_pkg::MODE_DAILY: begin
                sel = 1'b1;
            end
            cwt_pkg::MODE_WEEKDAYS: begin
                sel = (dow <= cwt_pkg::DOW_FRI);
            end
            cwt_pkg::MODE_MON_SAT: begin
                sel = (dow <= cwt_pkg::DOW_SAT);
            end
            cwt_pkg::MODE_WEEKEND: begin
                sel = (dow == cwt_pkg::DOW_SAT) ||
                      (dow == cwt_pkg::DOW_SUN);
            end
            default: begin
                if (mode >= cwt_pkg::MODE_MON &&
                    mode <= cwt_pkg::MODE_SUN) begin
                    sel = ((mode - cwt_pkg::MODE_MON) == {1'b0, dow});
                end
            end
        endcase
        return sel;
    endfunction

    // The calendar advances once a second; switching acts on that step.
    assign sec_tick = (CAL_TIME.tod.second != q_r.prev_sec);

    assign dow_prev = (CAL_TIME.dow == cwt_pkg::DOW_MON) ?
                      cwt_pkg::DOW_SUN : CAL_TIME.dow - 3'h1;

    genvar gi;
    generate
        for (gi = 0; gi < cwt_pkg::NUM_TIMERS; gi++) begin : g_day
            // Codes above the weekend mode are treated as disabled.
            assign in_use[gi] = (q_r.mode[gi] != cwt_pkg::MODE_OFF) &&
                                (q_r.mode[gi] <= cwt_pkg::MODE_WEEKEND);
            assign day_on_ok[gi] = day_selected(q_r.mode[gi], CAL_TIME.dow);
            // An off time earlier than the on time belongs to the next day.
            assign day_off_ok[gi] =
                (q_r.off_tod[gi] < q_r.on_tod[gi]) ?
                day_selected(q_r.mode[gi], dow_prev) :
                day_selected(q_r.mode[gi], CAL_TIME.dow);
        end
    endgenerate

    always_comb begin
        logic req;
        logic taken_wr;
        logic [3:0] idx;
        logic [3:0] reg_ofs;
        logic timer_hit;
        logic in_use_n;
        req = AVS_READ || AVS_WRITE;
        taken_wr = AVS_WRITE && !q_r.waitreq;
        idx = AVS_ADDRESS[7:4];
        reg_ofs = AVS_ADDRESS[3:0];
        timer_hit = (AVS_ADDRESS < cwt_pkg::MAP_TIMER_END);
        in_use_n = 1'b0;
        q_nxt = q_r;

        q_nxt.prev_sec = CAL_TIME.tod.second;

        // The first stage feeds only the second stage.
        q_nxt.pf_sync = {q_r.pf_sync[0], AUX_POWER_FAIL};

        // One wait state: requests are taken on the second edge.
        q_nxt.waitreq = !(req && q_r.waitreq);

        // Scheduled switching, only once the stored states are back.
        if (q_r.phase == cwt_pkg::CWT_RUN) begin
            for (int i = 0; i < cwt_pkg::NUM_TIMERS; i++) begin
                if (in_use[i] && sec_tick) begin
                    if (CAL_TIME.tod == q_r.on_tod[i] &&
                        day_on_ok[i]) begin
                        q_nxt.state[i] = 1'b1;
                    end
                    if (CAL_TIME.tod == q_r.off_tod[i] &&
                        day_off_ok[i]) begin
                        q_nxt.state[i] = 1'b0;
                    end
                end
            end
        end

        // Restore the saved states before any scheduled switching.
        case (q_r.phase)
            cwt_pkg::CWT_RESTORE: begin
                if (NV_LOAD_VALID) begin
                    q_nxt.state = NV_LOAD_DATA;
                    q_nxt.phase = cwt_pkg::CWT_RUN;
                end
            end
            cwt_pkg::CWT_RUN: begin
                q_nxt.phase = cwt_pkg::CWT_RUN;
            end
            default: begin
                q_nxt.phase = cwt_pkg::CWT_RESTORE;
            end
        endcase

        // Register writes take effect on the second edge, the one that takes the request.
        if (taken_wr && timer_hit) begin
            case (reg_ofs)
                cwt_pkg::OFS_ON[3:0]: begin
                    q_nxt.on_tod[idx[1:0]] = '{
                        AVS_WRITEDATA[cwt_pkg::HOUR_LSB +: 5],
                        AVS_WRITEDATA[cwt_pkg::MIN_LSB +: 6],
                        AVS_WRITEDATA[cwt_pkg::SEC_LSB +: 6]};
                end
                cwt_pkg::OFS_OFF[3:0]: begin
                    q_nxt.off_tod[idx[1:0]] = '{
                        AVS_WRITEDATA[cwt_pkg::HOUR_LSB +: 5],
                        AVS_WRITEDATA[cwt_pkg::MIN_LSB +: 6],
                        AVS_WRITEDATA[cwt_pkg::SEC_LSB +: 6]};
                end
                cwt_pkg::OFS_MODE[3:0]: begin
                    q_nxt.mode[idx[1:0]] = AVS_WRITEDATA[3:0];
                end
                cwt_pkg::OFS_STATUS[3:0]: begin
                    // A status write forces the output of a timer in use, with no extra flag.
                    if (in_use[idx[1:0]]) begin
                        q_nxt.state[idx[1:0]] =
                            AVS_WRITEDATA[cwt_pkg::STAT_OUT_BIT];
                    end
                end
                default: begin
                    q_nxt.state = q_nxt.state;
                end
            endcase
        end

        // Outputs follow the state only while the timer is in use.
        for (int i = 0; i < cwt_pkg::NUM_TIMERS; i++) begin
            in_use_n = (q_nxt.mode[i] != cwt_pkg::MODE_OFF) &&
                       (q_nxt.mode[i] <= cwt_pkg::MODE_WEEKEND);
            q_nxt.tout[i] = q_nxt.state[i] && in_use_n;
        end

        // Save every state once per power-fail assertion.
        q_nxt.save_stb = 1'b0;
        q_nxt.pf_seen = q_r.pf_sync[1];
        if (q_r.pf_sync[1] && !q_r.pf_seen) begin
            q_nxt.save_stb = 1'b1;
            q_nxt.save_data = q_r.state;
        end

        // Read data is ready by the edge on which the read is taken.
        if (AVS_READ && q_r.waitreq) begin
            q_nxt.rdata = 32'h00000000;
            if (timer_hit) begin
                case (reg_ofs)
                    cwt_pkg::OFS_ON[3:0]: begin
                        q_nxt.rdata[cwt_pkg::HOUR_LSB +: 5] =
                            q_r.on_tod[idx[1:0]].hour;
                        q_nxt.rdata[cwt_pkg::MIN_LSB +: 6] =
                            q_r.on_tod[idx[1:0]].minute;
                        q_nxt.rdata[cwt_pkg::SEC_LSB +: 6] =
                            q_r.on_tod[idx[1:0]].second;
                    end
                    cwt_pkg::OFS_OFF[3:0]: begin
                        q_nxt.rdata[cwt_pkg::HOUR_LSB +: 5] =
                            q_r.off_tod[idx[1:0]].hour;
                        q_nxt.rdata[cwt_pkg::MIN_LSB +: 6] =
                            q_r.off_tod[idx[1:0]].minute;
                        q_nxt.rdata[cwt_pkg::SEC_LSB +: 6] =
                            q_r.off_tod[idx[1:0]].second;
                    end
                    cwt_pkg::OFS_MODE[3:0]: begin
                        q_nxt.rdata[3:0] = q_r.mode[idx[1:0]];
                    end
                    cwt_pkg::OFS_STATUS[3:0]: begin
                        q_nxt.rdata[cwt_pkg::STAT_INUSE_BIT] =
                            in_use[idx[1:0]];
                        q_nxt.rdata[cwt_pkg::STAT_OUT_BIT] =
                            q_r.tout[idx[1:0]];
                    end
                    default: begin
                        q_nxt.rdata = 32'h00000000;
                    end
                endcase
            end else if (AVS_ADDRESS == cwt_pkg::OFS_CTRL) begin
                q_nxt.rdata[cwt_pkg::CTRL_RESTORED_BIT] =
                    (q_r.phase == cwt_pkg::CWT_RUN);
                q_nxt.rdata[cwt_pkg::CTRL_PFAIL_BIT] = q_r.pf_sync[1];
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            q_r <= cwt_pkg::STATE_RST;
        end else if (CE) begin
            q_r <= q_nxt;
        end
    end

    assign AVS_READDATA = q_r.rdata;
    assign AVS_WAITREQUEST = q_r.waitreq;
    assign NV_SAVE_STB = q_r.save_stb;
    assign NV_SAVE_DATA = q_r.save_data;
    assign TIMER_OUT = q_r.tout;

endmodule

`default_nettype wire

/* verification/cwt_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module cwt_checker (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [cwt_pkg::DATA_W-1:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire cwt_pkg::cwt_cal_t CAL_TIME,
    input wire logic AUX_POWER_FAIL,
    input wire logic NV_LOAD_VALID,
    input wire logic NV_SAVE_STB,
    input wire logic [cwt_pkg::NUM_TIMERS-1:0] NV_SAVE_DATA,
    input wire logic [cwt_pkg::NUM_TIMERS-1:0] TIMER_OUT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    a_wait_ans:
        assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CE
            |=> !AVS_WAITREQUEST) else $error("bus answer missing");
    a_wait_one:
        assert property (!AVS_WAITREQUEST && CE |=> AVS_WAITREQUEST)
        else $error("wait low too long");
    a_rdata_hold:
        assert property ($changed(AVS_READDATA) |-> $past(AVS_READ))
        else $error("read data moved without read");
    a_save_one:
        assert property (NV_SAVE_STB |=> !NV_SAVE_STB)
        else $error("save strobe too long");
    a_save_cause:
        assert property (NV_SAVE_STB |-> $past(AUX_POWER_FAIL, 3)
            && !$past(AUX_POWER_FAIL, 4)) else $error("save not at fail");
    a_save_data:
        assert property ($changed(NV_SAVE_DATA) |-> NV_SAVE_STB)
        else $error("save data moved alone");
    a_out_cause:
        assert property (TIMER_OUT != $past(TIMER_OUT) |->
            $past(CAL_TIME.tod.second) != $past(CAL_TIME.tod.second, 2)
            || $past(NV_LOAD_VALID)
            || ($past(AVS_WRITE) && !$past(AVS_WAITREQUEST)))
        else $error("output moved without cause");
    a_idle_rst:
        assert property ($rose(RST_N) |-> AVS_WAITREQUEST && !NV_SAVE_STB
            && TIMER_OUT == 4'h0) else $error("bad state after reset");
endmodule
`default_nettype wire

/* verification/cwt_nv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cwt_nv_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic save_stb,
    input wire logic [cwt_pkg::NUM_TIMERS-1:0] save_data,
    output logic load_valid,
    output logic [cwt_pkg::NUM_TIMERS-1:0] load_data,
    output logic [cwt_pkg::NUM_TIMERS-1:0] mem
);
    logic [1:0] cnt_r;
    initial mem = 4'h5;
    initial load_valid = 1'b0;
    // One load pulse per reset release; the data lines lie otherwise.
    always @(posedge clk) begin
        if (save_stb) mem <= save_data;
        if (!rst_n) begin
            cnt_r <= 2'h0;
            load_valid <= 1'b0;
        end else begin
            if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
            load_valid <= cnt_r == 2'h2;
        end
    end
    assign load_data = load_valid ? mem : ~mem;
endmodule
`default_nettype wire

/* verification/calendar_weekly_timers_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module calendar_weekly_timers_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic aux = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat, q;
    logic wait_r, ld_v, sv_stb;
    logic [3:0] ld_d, sv_d, outs, nv_mem;
    cwt_pkg::cwt_cal_t cal = '0;
    int errors = 0;
    int n_tests = 0;
    always #50 mclk = ~mclk;
    cwt_timers i_cwt_timers (.MCLK(mclk), .RST_N(rst_n), .CE(1'b1),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_r),
        .CAL_TIME(cal), .AUX_POWER_FAIL(aux), .NV_LOAD_VALID(ld_v),
        .NV_LOAD_DATA(ld_d), .NV_SAVE_STB(sv_stb), .NV_SAVE_DATA(sv_d),
        .TIMER_OUT(outs));
    cwt_nv_model i_cwt_nv_model (.clk(mclk), .rst_n(rst_n),
        .save_stb(sv_stb), .save_data(sv_d), .load_valid(ld_v),
        .load_data(ld_d), .mem(nv_mem));
    task automatic stop_test();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input int a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge mclk);
        adr <= 8'(a);
        wd <= d;
        wr <= w;
        rd <= !w;
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge mclk);
            done = (wait_r === 1'b0);
        end
        if (!done) begin
            errors++;
            stop_test();
        end
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic at(input int h, input int m, input int s, input int d);
        @(posedge mclk);
        cal <= {h[4:0], m[5:0], s[5:0], d[2:0]};
        repeat (2) @(posedge mclk);
    endtask
    function automatic logic [31:0] t(input int h, input int m, input int s);
        return {11'h0, h[4:0], 2'h0, m[5:0], 2'h0, s[5:0]};
    endfunction
    function automatic logic sel(input int m, input int d);
        return m == 1 || (m >= 2 && m <= 8 && d == m - 2) ||
            (m == 9 && d < 5) || (m == 10 && d < 6) || (m == 11 && d >= 5);
    endfunction
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        bus(0, 'h40, 0);
        chk("ctrl", 32'h1, q);
        for (int n = 0; n < 4; n++) begin
            bus(1, n * 16, t(n, n + 1, n + 2));
            bus(1, n * 16 + 4, t(n + 10, n + 20, n + 30));
            bus(1, n * 16 + 8, n + 9);
        end
        for (int n = 0; n < 4; n++) begin
            bus(0, n * 16, 0);
            chk("on", t(n, n + 1, n + 2), q);
            bus(0, n * 16 + 4, 0);
            chk("off", t(n + 10, n + 20, n + 30), q);
            bus(0, n * 16 + 8, 0);
            chk("mode", n + 9, q);
        end
        bus(1, 'h44, 32'hffffffff);
        bus(0, 'h44, 0);
        chk("unmapped", 0, q);
        bus(1, 0, t(1, 0, 0));
        bus(1, 4, t(2, 0, 0));
        for (int m = 0; m < 13; m++) begin
            bus(1, 8, m);
            for (int d = 0; d < 7; d++) begin
                bus(1, 'hc, 0);
                at(0, 59, 59, d);
                at(1, 0, 0, d);
                chk("act", sel(m, d), outs[0]);
                bus(0, 'hc, 0);
                chk("stat", {m > 0 && m < 12, sel(m, d)}, q);
                at(1, 59, 59, d);
                at(2, 0, 0, d);
                chk("deact", 0, outs[0]);
            end
        end
        bus(1, 8, 1);
        bus(1, 'hc, 1);
        // The output register loads on the edge that takes the write.
        @(posedge mclk);
        chk("force", 1, outs[0]);
        at(1, 59, 59, 0);
        chk("hold", 1, outs[0]);
        at(2, 0, 0, 0);
        chk("revert", 0, outs[0]);
        bus(1, 'hc, 1);
        bus(1, 8, 0);
        bus(1, 'hc, 0);
        bus(1, 8, 1);
        @(posedge mclk);
        chk("unused", 1, outs[0]);
        bus(1, 8, 2);
        bus(1, 'hc, 0);
        bus(1, 0, t(23, 0, 0));
        bus(1, 4, t(1, 0, 0));
        at(22, 59, 59, 0);
        chk("before on", 0, outs[0]);
        at(23, 0, 0, 0);
        chk("late on", 1, outs[0]);
        at(0, 59, 59, 1);
        chk("past midnight", 1, outs[0]);
        at(1, 0, 0, 1);
        chk("next day", 0, outs[0]);
        @(posedge mclk);
        aux <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("saved", 4'h4, nv_mem);
        bus(0, 'h40, 0);
        chk("pfail", 32'h3, q);
        aux <= 1'b0;
        rst_n <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        bus(1, 'h28, 1);
        bus(0, 'h2c, 0);
        chk("restored", 3, q);
        chk("outs", 4'h4, outs);
        stop_test();
    end
endmodule
bind cwt_timers cwt_checker i_cwt_checker (.MCLK(MCLK), .RST_N(RST_N),
    .CE(CE), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CAL_TIME(CAL_TIME), .AUX_POWER_FAIL(AUX_POWER_FAIL),
    .NV_LOAD_VALID(NV_LOAD_VALID), .NV_SAVE_STB(NV_SAVE_STB),
    .NV_SAVE_DATA(NV_SAVE_DATA), .TIMER_OUT(TIMER_OUT));
`default_nettype wire
